// ---- src/modem_cfg_params.svh ----
// register offsets, field positions, reset values and timing counts of the modem configuration block
`ifndef MODEM_CFG_PARAMS_SVH
`define MODEM_CFG_PARAMS_SVH
`define OFS_TX_MOD 12'h008
`define OFS_CLK_DIV 12'h00C
`define OFS_DEMOD 12'h010
`define OFS_IF_FILT 12'h014
`define OFS_FINE_CAL 12'h018
`define OFS_READBACK 12'h01C
`define OFS_MODE 12'h020
`define OFS_STATUS 12'h024
`define OFS_SCRATCH_BASE 5'h08
`define NUM_CFG_REGS 6
`define RESET_WORD 32'h0000_0000
// transmit_modulation fields
`define TXM_PA_ON 7
`define TXM_RAMP_LSB 8
`define TXM_LEVEL_LSB 13
`define TXM_DEV_LSB 19
`define TXM_SCHEME_LSB 28
`define TXM_ALPHA 31
// clock_divider_setup fields
`define CDV_BBOS_LSB 4
`define CDV_DEMOD_LSB 6
`define CDV_CDR_LSB 10
`define CDV_SEQ_LSB 18
`define CDV_AGC_LSB 26
// if_filter_setup fields
`define IFF_COARSE 4
`define IFF_ADJ_LSB 14
// fine_calibration_setup fields
`define FCS_FINE_EN 4
`define FCS_DWELL_LSB 5
`define FCS_IMG_STR_LSB 28
`define FCS_IMG_HALF 30
// mode register fields
`define MOD_TX 0
`define MOD_RX 1
`define MOD_ADC_UP 2
// counts
`define FINE_TONE_PERIODS 4'hA
`define COARSE_CYCLES 16'h0040
`define DEV_SHIFT 16
`endif

// ---- src/modem_cfg_pkg.sv ----
// types shared by the modem configuration block
package modem_cfg_pkg;
  typedef enum logic [3:0] {
    CAL_IDLE = 4'h1,
    CAL_COARSE = 4'h2,
    CAL_FINE = 4'h4,
    CAL_DONE = 4'h8
  } cal_state_e;
  typedef enum logic [2:0] {
    PA_OFF = 3'h1,
    PA_UP = 3'h2,
    PA_DOWN = 3'h4
  } pa_state_e;
endpackage : modem_cfg_pkg

// ---- src/cfg_bus_if.sv ----
// write and read port bundle between the bus slave and the register store
`timescale 1ns/1ps
`default_nettype none
interface cfg_bus_if;
  logic we;
  logic [2:0] idx;
  logic [31:0] wdata;
  logic [2:0] ridx;
  logic [31:0] rdata;
  modport ctl (output we, output idx, output wdata, output ridx, input rdata);
  modport mem (input we, input idx, input wdata, input ridx, output rdata);
endinterface : cfg_bus_if
`default_nettype wire

// ---- src/cfg_word_store.sv ----
// small register store for the configuration words, registered read data
`include "modem_cfg_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_word_store #(
  parameter int DEPTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  cfg_bus_if.mem bus
);
  logic [31:0] mem_q [DEPTH];
  logic [31:0] mem_d [DEPTH];
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = (bus.we && bus.idx == 3'(i)) ? bus.wdata : mem_q[i];
    end
    rd_d = (int'(bus.ridx) < DEPTH) ? mem_q[bus.ridx] : `RESET_WORD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `RESET_WORD;
      end
      rd_q <= `RESET_WORD;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign bus.rdata = rd_q;
endmodule : cfg_word_store
`default_nettype wire

// ---- src/radio_modem_config_and_cal.sv ----
// configuration registers, clock dividers, amplifier ramp and filter calibration sequencer
`include "modem_cfg_params.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_modem_config_and_cal (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] phase_compare_frequency_khz,
  output logic [24:0] deviation_hz,
  output logic [2:0] tone_multiplier,
  output logic tone_negative,
  output logic [5:0] amplifier_level,
  output logic amplifier_on,
  output logic rolloff_wide,
  output logic baseband_offset_clock,
  output logic demod_clock,
  output logic recovery_clock,
  output logic sequencer_clock,
  output logic gain_update_clock,
  output logic cal_busy,
  output logic cal_complete,
  output logic [5:0] filter_adjust,
  output logic [1:0] image_source_strength,
  output logic image_source_halved,
  output logic strength_readback_valid,
  output logic voltage_readback_valid,
  output logic adc_powered
);
  localparam int NREG = `NUM_CFG_REGS;

  cfg_bus_if bus ();
  cfg_word_store #(.DEPTH(NREG)) u_store (.pclk(pclk), .presetn(presetn), .bus(bus));

  // shadow copies so field decode does not wait on the store's read port
  logic [31:0] txm_q, cdv_q, iff_q, fcs_q, mode_q;
  logic [31:0] txm_d, cdv_d, iff_d, fcs_d, mode_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic rd_pend_q, rd_pend_d;
  logic cal_kick_q, cal_kick_d;

  function automatic logic [2:0] addr_index(input logic [11:0] a);
    return 3'(a[4:2] - 3'd2);
  endfunction : addr_index

  wire logic setup = psel && !penable;
  wire logic cfg_hit = (paddr >= `OFS_TX_MOD) && (paddr <= `OFS_READBACK) && (paddr[1:0] == 2'b00);
  wire logic mode_hit = paddr == `OFS_MODE;
  wire logic stat_hit = paddr == `OFS_STATUS;
  wire logic wr_now = setup && pwrite && (pstrb == 4'hF);
  wire logic [31:0] status_word = {26'h0, adc_powered, voltage_readback_valid, strength_readback_valid,
                                   cal_complete, cal_busy, amplifier_on};

  // one wait state for configuration word reads only, none for other accesses: setup is decoded, access phase answers
  always_comb begin
    txm_d = txm_q;
    cdv_d = cdv_q;
    iff_d = iff_q;
    fcs_d = fcs_q;
    mode_d = mode_q;
    pready_d = setup;
    pslverr_d = setup && !(cfg_hit || mode_hit || stat_hit);
    rd_pend_d = setup && !pwrite && cfg_hit;
    prdata_d = prdata_q;
    cal_kick_d = 1'b0;
    bus.we = 1'b0;
    bus.idx = addr_index(paddr);
    bus.wdata = pwdata;
    bus.ridx = addr_index(paddr);
    if (setup && pwrite && pstrb != 4'hF) begin
      // partial writes refused so a word never lands half updated
      pslverr_d = 1'b1;
    end
    if (wr_now && cfg_hit) begin
      bus.we = 1'b1;
      unique case (paddr)
        `OFS_TX_MOD: txm_d = pwdata;
        `OFS_CLK_DIV: cdv_d = pwdata;
        `OFS_IF_FILT: begin
          iff_d = pwdata;
          cal_kick_d = pwdata[`IFF_COARSE];
        end
        `OFS_FINE_CAL: fcs_d = pwdata;
        default: ;
      endcase
    end
    if (wr_now && mode_hit) begin
      mode_d = {29'h0, pwdata[2:0]};
    end
    if (setup && !pwrite) begin
      prdata_d = mode_hit ? mode_q : stat_hit ? status_word : `RESET_WORD;
    end
    if (rd_pend_q) begin
      prdata_d = bus.rdata;
      pready_d = 1'b1;
    end
    if (rd_pend_d) begin
      pready_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txm_q <= `RESET_WORD;
      cdv_q <= `RESET_WORD;
      iff_q <= `RESET_WORD;
      fcs_q <= `RESET_WORD;
      mode_q <= `RESET_WORD;
      prdata_q <= `RESET_WORD;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      cal_kick_q <= 1'b0;
    end else begin
      txm_q <= txm_d;
      cdv_q <= cdv_d;
      iff_q <= iff_d;
      fcs_q <= fcs_d;
      mode_q <= mode_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rd_pend_q <= rd_pend_d;
      cal_kick_q <= cal_kick_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // clock dividers; each output toggles at half its divide count
  logic [4:0] div_cnt_q [5], div_cnt_d [5];
  logic [4:0] div_clk_q, div_clk_d;
  logic [4:0] div_val [5];
  logic [4:0] seq_tick;
  always_comb begin
    div_val[0] = {2'b0, 1'b1, cdv_q[`CDV_BBOS_LSB +: 2]};
    div_val[1] = {1'b0, cdv_q[`CDV_DEMOD_LSB +: 4]};
    div_val[2] = cdv_q[`CDV_CDR_LSB +: 5];
    div_val[3] = cdv_q[`CDV_SEQ_LSB +: 5];
    div_val[4] = cdv_q[`CDV_AGC_LSB +: 5];
    for (int i = 0; i < 5; i++) begin
      seq_tick[i] = (div_cnt_q[i] == 5'h0);
      // recovery and gain dividers run off their parent's ticks
      div_cnt_d[i] = div_cnt_q[i];
      div_clk_d[i] = div_clk_q[i];
      if ((i == 2 && seq_tick[1] || i == 4 && seq_tick[3] || i < 2 || i == 3)) begin
        div_cnt_d[i] = seq_tick[i] ? ((div_val[i] > 5'h1) ? div_val[i] - 5'h1 : 5'h0) : div_cnt_q[i] - 5'h1;
        // toggling at the wrap and at mid count keeps the period equal to the divide count for counts of 2 or more; 0 and 1 give a period of 2
        div_clk_d[i] = (seq_tick[i] || div_cnt_q[i] == (div_val[i] >> 1)) ? ~div_clk_q[i] : div_clk_q[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) begin
        div_cnt_q[i] <= 5'h0;
      end
      div_clk_q <= 5'h0;
    end else begin
      div_cnt_q <= div_cnt_d;
      div_clk_q <= div_clk_d;
    end
  end
  assign baseband_offset_clock = div_clk_q[0];
  assign demod_clock = div_clk_q[1];
  assign recovery_clock = div_clk_q[2];
  assign sequencer_clock = div_clk_q[3];
  assign gain_update_clock = div_clk_q[4];

  // modulation outputs
  logic [24:0] dev_q, dev_d;
  logic [2:0] tone_q, tone_d;
  logic neg_q, neg_d, alpha_q, alpha_d;
  always_comb begin
    // 64-bit product: full-scale field times full-scale frequency overflows 32 bits
    dev_d = 25'((64'(txm_q[`TXM_DEV_LSB +: 9]) * 64'(phase_compare_frequency_khz) * 64'h3E8) >> `DEV_SHIFT);
    if (txm_q[`TXM_SCHEME_LSB +: 3] == 3'h7) begin
      dev_d = dev_d >> 1;
    end
    // four-level schemes alternate outer and inner tones with the sequencer clock level, outer while it is high
    tone_d = (txm_q[`TXM_SCHEME_LSB +: 3] == 3'h3 || txm_q[`TXM_SCHEME_LSB +: 3] == 3'h6)
             ? (div_clk_q[3] ? 3'h3 : 3'h1) : 3'h1;
    neg_d = div_clk_q[4];
    alpha_d = txm_q[`TXM_ALPHA];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_q <= 25'h0;
      tone_q <= 3'h1;
      neg_q <= 1'b0;
      alpha_q <= 1'b0;
    end else begin
      dev_q <= dev_d;
      tone_q <= tone_d;
      neg_q <= neg_d;
      alpha_q <= alpha_d;
    end
  end
  assign deviation_hz = dev_q;
  assign tone_multiplier = tone_q;
  assign tone_negative = neg_q;
  assign rolloff_wide = alpha_q;

  // amplifier ramp
  modem_cfg_pkg::pa_state_e pa_q, pa_d;
  logic [5:0] lvl_q, lvl_d;
  logic [7:0] ramp_cnt_q, ramp_cnt_d;
  logic pa_out_q, pa_out_d;
  wire logic [5:0] lvl_target = txm_q[`TXM_LEVEL_LSB +: 6];
  wire logic [7:0] ramp_period = 8'h1 << (3'h7 - txm_q[`TXM_RAMP_LSB +: 3]);
  wire logic want_on = mode_q[`MOD_TX] && txm_q[`TXM_PA_ON];
  wire logic step = ramp_cnt_q == 8'h0;
  always_comb begin
    pa_d = pa_q;
    lvl_d = lvl_q;
    ramp_cnt_d = step ? ramp_period : ramp_cnt_q - 8'h1;
    pa_out_d = lvl_q != 6'h0;
    unique case (pa_q)
      modem_cfg_pkg::PA_OFF: if (want_on) pa_d = modem_cfg_pkg::PA_UP;
      modem_cfg_pkg::PA_UP: begin
        if (txm_q[`TXM_RAMP_LSB +: 3] == 3'h0) lvl_d = lvl_target; // no ramp
        else if (step && lvl_q < lvl_target) lvl_d = lvl_q + 6'h1;
        else if (step && lvl_q > lvl_target) lvl_d = lvl_q - 6'h1;
        if (!txm_q[`TXM_PA_ON]) pa_d = modem_cfg_pkg::PA_DOWN;
      end
      modem_cfg_pkg::PA_DOWN: begin
        if (step && lvl_q != 6'h0) lvl_d = lvl_q - 6'h1;
        if (lvl_q == 6'h0 || txm_q[`TXM_RAMP_LSB +: 3] == 3'h0) begin
          lvl_d = 6'h0;
          pa_d = modem_cfg_pkg::PA_OFF;
        end
      end
    endcase
    if (!mode_q[`MOD_TX]) begin
      // leaving transmit drops the amplifier at once, no down ramp
      lvl_d = 6'h0;
      pa_d = modem_cfg_pkg::PA_OFF;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_q <= modem_cfg_pkg::PA_OFF;
      lvl_q <= 6'h0;
      ramp_cnt_q <= 8'h0;
      pa_out_q <= 1'b0;
    end else begin
      pa_q <= pa_d;
      lvl_q <= lvl_d;
      ramp_cnt_q <= ramp_cnt_d;
      pa_out_q <= pa_out_d;
    end
  end
  assign amplifier_level = lvl_q;
  assign amplifier_on = pa_out_q;

  // filter calibration sequencer; dwell counts sequencer ticks
  modem_cfg_pkg::cal_state_e cal_q, cal_d;
  logic [15:0] cal_cnt_q, cal_cnt_d;
  logic [3:0] tone_idx_q, tone_idx_d;
  logic seq_rise;
  logic seq_prev_q;
  logic [5:0] adj_q, adj_d;
  always_comb begin
    cal_d = cal_q;
    cal_cnt_d = cal_cnt_q;
    tone_idx_d = tone_idx_q;
    adj_d = adj_q;
    seq_rise = div_clk_q[3] && !seq_prev_q;
    unique case (cal_q)
      modem_cfg_pkg::CAL_IDLE, modem_cfg_pkg::CAL_DONE: begin
        if (cal_kick_q) begin
          cal_d = modem_cfg_pkg::CAL_COARSE;
          cal_cnt_d = `COARSE_CYCLES;
          adj_d = iff_q[`IFF_ADJ_LSB +: 6];
        end
      end
      modem_cfg_pkg::CAL_COARSE: begin
        cal_cnt_d = cal_cnt_q - 16'h1;
        if (cal_cnt_q == 16'h1) begin
          if (fcs_q[`FCS_FINE_EN]) begin
            cal_d = modem_cfg_pkg::CAL_FINE;
            cal_cnt_d = {3'h0, fcs_q[`FCS_DWELL_LSB +: 13]};
            tone_idx_d = 4'h0;
          end else begin
            cal_d = modem_cfg_pkg::CAL_DONE;
          end
        end
      end
      modem_cfg_pkg::CAL_FINE: begin
        if (seq_rise) begin
          cal_cnt_d = cal_cnt_q - 16'h1;
          if (cal_cnt_q <= 16'h1) begin
            cal_cnt_d = {3'h0, fcs_q[`FCS_DWELL_LSB +: 13]};
            tone_idx_d = tone_idx_q + 4'h1;
            if (tone_idx_q == `FINE_TONE_PERIODS - 4'h1) begin
              cal_d = modem_cfg_pkg::CAL_DONE;
              adj_d = 6'(adj_q + 6'(tone_idx_q));
            end
          end
        end
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= modem_cfg_pkg::CAL_IDLE;
      cal_cnt_q <= 16'h0;
      tone_idx_q <= 4'h0;
      seq_prev_q <= 1'b0;
      adj_q <= 6'h0;
    end else begin
      cal_q <= cal_d;
      cal_cnt_q <= cal_cnt_d;
      tone_idx_q <= tone_idx_d;
      seq_prev_q <= div_clk_q[3];
      adj_q <= adj_d;
    end
  end

  // calibration flags, image source bits, readback validity and converter power, registered
  logic busy_q, done_q, str_q, half_q, rssi_q, volt_q, adc_q;
  logic [1:0] strn_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      strn_q <= 2'h0;
      half_q <= 1'b0;
      rssi_q <= 1'b0;
      volt_q <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      busy_q <= cal_d == modem_cfg_pkg::CAL_COARSE || cal_d == modem_cfg_pkg::CAL_FINE;
      done_q <= cal_d == modem_cfg_pkg::CAL_DONE;
      strn_q <= fcs_q[`FCS_IMG_STR_LSB +: 2];
      half_q <= fcs_q[`FCS_IMG_HALF];
      rssi_q <= mode_q[`MOD_RX];
      volt_q <= !mode_q[`MOD_RX] && (!mode_q[`MOD_TX] || mode_q[`MOD_ADC_UP]);
      adc_q <= !mode_q[`MOD_TX] || mode_q[`MOD_ADC_UP];
    end
  end
  assign cal_busy = busy_q;
  assign cal_complete = done_q;
  assign filter_adjust = adj_q;
  assign image_source_strength = strn_q;
  assign image_source_halved = half_q;
  assign strength_readback_valid = rssi_q;
  assign voltage_readback_valid = volt_q;
  assign adc_powered = adc_q;
endmodule : radio_modem_config_and_cal
`default_nettype wire

// ---- dv/modem_cfg_chk.sv ----
// concurrent checks on the port behaviour of the modem configuration block
`timescale 1ns/1ps
`default_nettype none
module modem_cfg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] tone_multiplier,
  input wire logic rolloff_wide,
  input wire logic cal_busy,
  input wire logic cal_complete,
  input wire logic [1:0] image_source_strength,
  input wire logic image_source_halved,
  input wire logic strength_readback_valid,
  input wire logic voltage_readback_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup, good_wr, mapped, coarse_wr, alpha_bit;
  logic [2:0] img_bits;
  assign setup = psel && !penable;
  assign good_wr = setup && pwrite && pstrb == 4'hF;
  assign mapped = paddr[1:0] == 2'h0 && paddr >= 12'h008 && paddr <= 12'h024;
  assign coarse_wr = good_wr && paddr == 12'h014 && pwdata[4];
  assign img_bits = pwdata[30:28];
  assign alpha_bit = pwdata[31];
  sequence s_coarse_idle; coarse_wr && !cal_busy; endsequence
  sequence s_fine_wr; good_wr && paddr == 12'h018; endsequence
  sequence s_tx_wr; good_wr && paddr == 12'h008; endsequence
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_write_answer; setup && pwrite |=> pready; endproperty
  property p_refuse; setup && (!mapped || (pwrite && pstrb != 4'hF)) |=> pready && pslverr; endproperty
  property p_cal_start; s_coarse_idle |-> ##[1:2] cal_busy; endproperty
  property p_cal_cause; $rose(cal_busy) |-> $past(coarse_wr) || $past(coarse_wr, 2); endproperty
  property p_busy_min; $rose(cal_busy) |-> cal_busy [*8]; endproperty
  property p_done; $fell(cal_busy) |-> cal_complete; endproperty
  property p_tone; tone_multiplier == 3'h1 || tone_multiplier == 3'h3; endproperty
  property p_rb_excl; !(strength_readback_valid && voltage_readback_valid); endproperty
  property p_image;
    s_fine_wr |-> ##2 {image_source_halved, image_source_strength} == $past(img_bits, 2);
  endproperty
  property p_alpha; s_tx_wr |-> ##2 rolloff_wide == $past(alpha_bit, 2); endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_write_answer: assert property (p_write_answer) else $error("write not answered next cycle");
  a_refuse: assert property (p_refuse) else $error("bad access not refused");
  a_cal_start: assert property (p_cal_start) else $error("coarse write did not start calibration");
  a_cal_cause: assert property (p_cal_cause) else $error("calibration started without coarse write");
  a_busy_min: assert property (p_busy_min) else $error("calibration ended too soon");
  a_done: assert property (p_done) else $error("calibration end without complete flag");
  a_tone: assert property (p_tone) else $error("tone multiplier not one or three");
  a_rb_excl: assert property (p_rb_excl) else $error("strength and voltage readback valid together");
  a_image: assert property (p_image) else $error("image source bits not copied");
  a_alpha: assert property (p_alpha) else $error("roll-off bit not copied");
endmodule : modem_cfg_chk
bind radio_modem_config_and_cal modem_cfg_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .tone_multiplier, .rolloff_wide, .cal_busy, .cal_complete,
  .image_source_strength, .image_source_halved, .strength_readback_valid, .voltage_readback_valid);
`default_nettype wire

// ---- dv/apb_host.sv ----
// host model: apb master that programs the configuration words
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  // whole word held from setup until pready; idle bus shows inverted data, not stale values
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the modem configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] f;
    logic e;
    logic [24:0] dv;
  } row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [15:0] phase_compare_frequency_khz = 16'h0000;
  logic [24:0] deviation_hz;
  logic [2:0] tone_multiplier;
  logic [5:0] amplifier_level, filter_adjust;
  logic [1:0] image_source_strength;
  logic tone_negative, amplifier_on, rolloff_wide, baseband_offset_clock, demod_clock, recovery_clock;
  logic sequencer_clock, gain_update_clock, cal_busy, cal_complete, image_source_halved;
  logic strength_readback_valid, voltage_readback_valid, adc_powered;
  int miscompares = 0;
  int checks = 0;
  int n1, n2;
  row_s rows [9];
  always #2.5 pclk = ~pclk;
  radio_modem_config_and_cal u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .phase_compare_frequency_khz, .deviation_hz, .tone_multiplier, .tone_negative,
    .amplifier_level, .amplifier_on, .rolloff_wide, .baseband_offset_clock, .demod_clock, .recovery_clock,
    .sequencer_clock, .gain_update_clock, .cal_busy, .cal_complete, .filter_adjust, .image_source_strength,
    .image_source_halved, .strength_readback_valid, .voltage_readback_valid, .adc_powered);
  apb_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  function automatic logic [31:0] tx(input logic [8:0] dev, input logic [2:0] sch, input logic al);
    return {al, sch, dev, 19'h00000};
  endfunction : tx
  task automatic close_out();
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ok;
    u_host.xfer(w, a, d, s, rdat, rerr, ok);
    chk("handshake", 32'h1, 32'(ok));
    if (ok !== 1'b1) close_out();
  endtask : xfer
  // counts levels strictly between off and full scale while waiting for the target
  task automatic amp_wait(input logic [5:0] v, output int mid);
    mid = 0;
    for (int i = 0; i < 20000 && amplifier_level !== v; i++) begin
      @(posedge pclk);
      if (amplifier_level != 6'h00 && amplifier_level != 6'h3F) mid++;
    end
    chk("amplifier_level", 32'(v), 32'(amplifier_level));
    if (amplifier_level !== v) close_out();
  endtask : amp_wait
  task automatic cal_len(input int bound, output int n);
    n = 0;
    for (int i = 0; i < bound; i++) begin
      @(posedge pclk);
      if (cal_busy === 1'b1) n++;
      else if (n > 0) break;
    end
    chk("cal_settled", 32'h0, 32'(cal_busy));
    if (cal_busy !== 1'b0) close_out();
  endtask : cal_len
  // rising edges over 40 pclk of each derived clock; every period used divides 40
  task automatic rate_check();
    logic [5:0] prv;
    logic [5:0] cur;
    int rise [6];
    int three;
    three = 0;
    foreach (rise[k]) rise[k] = 0;
    prv = {tone_negative, gain_update_clock, sequencer_clock, recovery_clock, demod_clock, baseband_offset_clock};
    repeat (40) begin
      @(posedge pclk);
      cur = {tone_negative, gain_update_clock, sequencer_clock, recovery_clock, demod_clock, baseband_offset_clock};
      for (int k = 0; k < 6; k++) begin
        if (cur[k] === 1'b1 && prv[k] === 1'b0) rise[k]++;
      end
      prv = cur;
      if (tone_multiplier === 3'h3) three++;
    end
    chk("baseband_offset_clock", 32'h8, 32'(rise[0]));
    chk("demod_clock", 32'h14, 32'(rise[1]));
    chk("recovery_clock", 32'hA, 32'(rise[2]));
    chk("sequencer_clock", 32'h14, 32'(rise[3]));
    chk("gain_update_clock", 32'hA, 32'(rise[4]));
    chk("tone_negative", 32'hA, 32'(rise[5]));
    chk("tone_outer", 32'h14, 32'(three));
  endtask : rate_check
  initial begin
    rows = '{'{12'h008, tx(9'h100, 3'h0, 1'b0), 4'hF, 16'h0100, 1'b0, 25'h00003E8},
             '{12'h008, tx(9'h100, 3'h7, 1'b1), 4'hF, 16'h0100, 1'b0, 25'h00001F4},
             '{12'h008, tx(9'h1FF, 3'h0, 1'b1), 4'hF, 16'h03E8, 1'b0, 25'h0001E75},
             '{12'h008, tx(9'h1FF, 3'h7, 1'b0), 4'hF, 16'h03E8, 1'b0, 25'h0000F3A},
             '{12'h008, tx(9'h001, 3'h0, 1'b0), 4'hF, 16'hFFFF, 1'b0, 25'h00003E7},
             '{12'h030, tx(9'h005, 3'h0, 1'b0), 4'hF, 16'hFFFF, 1'b1, 25'h00003E7},
             '{12'h008, tx(9'h009, 3'h0, 1'b0), 4'h3, 16'hFFFF, 1'b1, 25'h00003E7},
             '{12'h01C, 32'h0000_0001, 4'hF, 16'hFFFF, 1'b0, 25'h00003E7},
             '{12'h010, 32'h0000_1234, 4'hF, 16'hFFFF, 1'b0, 25'h00003E7}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      phase_compare_frequency_khz <= rows[i].f;
      xfer(1'b1, rows[i].a, rows[i].d, rows[i].s);
      repeat (3) @(posedge pclk);
      chk("pslverr", 32'(rows[i].e), 32'(rerr));
      chk("deviation_hz", 32'(rows[i].dv), 32'(deviation_hz));
      chk("rolloff_wide", 32'(rows[i].d[31]), 32'(rolloff_wide));
    end
    xfer(1'b1, 12'h020, 32'h1);
    xfer(1'b1, 12'h008, 32'h0007E180);
    amp_wait(6'h3F, n1);
    chk("amplifier_on", 32'h1, 32'(amplifier_on));
    xfer(1'b1, 12'h008, 32'h0007E100);
    amp_wait(6'h00, n1);
    chk("ramp_down_steps", 32'h1, 32'(n1 > 0));
    xfer(1'b1, 12'h008, 32'h0007E180);
    amp_wait(6'h3F, n1);
    xfer(1'b1, 12'h020, 32'h0);
    amp_wait(6'h00, n1);
    chk("hard_off_steps", 32'h0, 32'(n1));
    xfer(1'b1, 12'h008, 32'h30000000);
    // divide counts set small so the sequencer ticks every second pclk for a short run
    xfer(1'b1, 12'h00C, 32'h08080890);
    repeat (8) @(posedge pclk);
    rate_check();
    xfer(1'b1, 12'h014, 32'h00054010);
    cal_len(5000, n1);
    chk("coarse_busy_min", 32'h1, 32'(n1 >= 63));
    chk("cal_complete", 32'h1, 32'(cal_complete));
    chk("filter_adjust", 32'h15, 32'(filter_adjust));
    xfer(1'b1, 12'h018, 32'h60000050);
    repeat (3) @(posedge pclk);
    chk("image_source_strength", 32'h2, 32'(image_source_strength));
    chk("image_source_halved", 32'h1, 32'(image_source_halved));
    xfer(1'b0, 12'h018, 32'h0, 4'h0);
    chk("fine_calibration_setup", 32'h60000050, rdat);
    xfer(1'b1, 12'h014, 32'h00054010);
    cal_len(20000, n2);
    chk("fine_follows", 32'h1, 32'(n2 >= n1 + 20));
    chk("cal_busy", 32'h0, 32'(cal_busy));
    xfer(1'b1, 12'h014, 32'h00054000);
    cal_len(100, n2);
    chk("no_cal_without_coarse", 32'h0, 32'(n2));
    xfer(1'b1, 12'h020, 32'h2);
    repeat (3) @(posedge pclk);
    chk("voltage_readback_valid", 32'h0, 32'(voltage_readback_valid));
    xfer(1'b1, 12'h020, 32'h1);
    repeat (3) @(posedge pclk);
    chk("strength_readback_valid", 32'h0, 32'(strength_readback_valid));
    chk("adc_powered", 32'h0, 32'(adc_powered));
    xfer(1'b1, 12'h020, 32'h5);
    repeat (3) @(posedge pclk);
    chk("adc_powered", 32'h1, 32'(adc_powered));
    xfer(1'b0, 12'h024, 32'h0, 4'h0);
    chk("status_adc", 32'h1, 32'(rdat[5]));
    chk("status_cal_complete", 32'h1, 32'(rdat[2]));
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("deviation_hz", 32'h0, 32'(deviation_hz));
    chk("tone_multiplier", 32'h1, 32'(tone_multiplier));
    chk("rolloff_wide", 32'h0, 32'(rolloff_wide));
    chk("adc_powered", 32'h0, 32'(adc_powered));
    presetn <= 1'b1;
    @(posedge pclk);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
